/* File: temperature_alarm_gpio_pkg.sv */
// constants, register map and enumerations for the temperature alarm block
// assumes a 100 MHz system clock and an apb3 bus with 32-bit data
package temperature_alarm_gpio_pkg;

    // sizes
    localparam int LINES = 8;          // general-purpose lines and alarms
    localparam int CHANNELS = 8;       // temperature channels
    localparam int TEMP_W = 32;        // signed temperature word
    localparam int ADDR_W = 12;        // apb byte address width
    localparam int NV_ADDR_W = 5;      // {alarm, word} storage address

    // timing
    localparam int CLK_KHZ = 100_000;  // clock rate in kHz
    localparam int HALF_SEC_MS = 500;  // acquisition period per channel
    localparam int HALF_SEC_CYCLES = HALF_SEC_MS * CLK_KHZ / 1000 * 1000;

    // register byte offsets
    localparam logic [11:0] DIR_OFS = 12'h000;    // 1 = line is output
    localparam logic [11:0] OUT_OFS = 12'h004;    // software output level
    localparam logic [11:0] IN_OFS = 12'h008;     // synced pin levels
    localparam logic [11:0] STAT_OFS = 12'h00C;   // sticky events, w1c
    localparam logic [11:0] MASK_OFS = 12'h010;   // interrupt mask
    localparam logic [11:0] STATE_OFS = 12'h014;  // alarm states, loaded
    localparam logic [11:0] TEMP_BASE = 12'h020;  // 8 latest temperatures
    localparam logic [11:0] ALARM_BASE = 12'h040; // 16 bytes per alarm
    localparam logic [11:0] ALARM_END = 12'h0C0;

    // word index inside one alarm block
    localparam logic [1:0] AW_CFG = 2'h0;
    localparam logic [1:0] AW_T1 = 2'h1;
    localparam logic [1:0] AW_T2 = 2'h2;

    // configuration word fields
    localparam int CFG_CH_LSB = 0;
    localparam int CFG_IM_LSB = 4;
    localparam int CFG_OM_LSB = 8;
    localparam int STAT_W = 9;         // 8 alarm events + load done
    localparam int STAT_LOADED_BIT = 8;
    localparam int STATE_LOADED_BIT = 8;

    // alarm input modes
    typedef enum logic [2:0] {
        IM_ABOVE = 3'h0,
        IM_ABOVE_LATCH = 3'h1,
        IM_BELOW = 3'h2,
        IM_BELOW_LATCH = 3'h3,
        IM_WINDOW = 3'h4
    } in_mode_type;

    // alarm output modes
    typedef enum logic [1:0] {
        OM_DISABLED = 2'h0,
        OM_ACTIVE_HIGH = 2'h1,
        OM_ACTIVE_LOW = 2'h2
    } out_mode_type;

    // configuration loader
    typedef enum logic [1:0] {
        ST_REQ = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } load_state_type;

endpackage : temperature_alarm_gpio_pkg

/* File: temperature_alarm_gpio.sv */
// temperature alarms driving eight general-purpose lines, apb registers
// assumes a converter on the same clock that answers sample requests and
// a word-wide non-volatile store answering reads with a valid pulse
`timescale 1ns/100ps

// How it works
// - eight lines, each direction set separately
// - lines come up inputs unless alarm enabled
// - eight alarms, each owning one line
// - each alarm selects any temperature channel
// - enabled alarm makes line output, drives it
// - alarm settings loaded from storage at reset
// - alarms run logging or host attached
// - above modes, optional latch until below second
// - below modes, optional latch until above second
// - window mode: below first or above second
// - both thresholds stored per alarm
// - disabled alarm leaves line to software
// - active high drives high on alarm
// - active low drives low on alarm
// - sample every channel twice per second
// - sample readable by host at once
// - logging card gets each channel once per second
module temperature_alarm_gpio #(
    parameter int HALF_SEC_CYCLES = temperature_alarm_gpio_pkg::HALF_SEC_CYCLES
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // general-purpose lines
    input wire logic [7:0] gp_line_i,
    output logic [7:0] gp_line_o,
    output logic [7:0] gp_line_oe_n_o,
    // temperature acquisition
    output logic sample_req_o,
    input wire logic sample_valid_i,
    input wire logic [2:0] sample_ch_i,
    input wire logic [31:0] sample_data_i,
    // logging card and host presence
    input wire logic host_attached_i,
    output logic log_valid_o,
    output logic [2:0] log_ch_o,
    output logic [31:0] log_data_o,
    // non-volatile configuration store
    output logic nv_rd_o,
    output logic nv_wr_o,
    output logic [4:0] nv_addr_o,
    output logic [31:0] nv_wdata_o,
    input wire logic [31:0] nv_rdata_i,
    input wire logic nv_rvalid_i,
    // interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] pin_meta_q; // first sync stage, pins
    logic [7:0] pin_sync_q; // second sync stage, pins
    logic host_meta_q; // first sync stage, host
    logic host_sync_q; // second sync stage, host
    logic [31:0] tick_cnt_q; // half-second counter
    logic half_tick; // one pulse per half second
    logic sec_phase_q; // toggles each half second
    logic sec_tick; // one pulse per second
    logic [31:0] temp_q [8]; // latest sample per channel
    logic [31:0] cfg_q [8]; // alarm configuration words
    logic [31:0] t1_q [8]; // first threshold per alarm
    logic [31:0] t2_q [8]; // second threshold per alarm
    logic [7:0] dir_q; // software direction, 1 = out
    logic [7:0] out_q; // software output levels
    logic [8:0] stat_q; // sticky events
    logic [8:0] mask_q; // interrupt enables
    logic [7:0] alarm_state; // current alarm per line
    logic [7:0] alarm_rise; // alarm newly raised this tick
    logic [7:0] alarm_drive; // alarm owns its line
    logic [7:0] alarm_level; // level an alarm wants on line
    logic [7:0] pin_q; // registered line level
    logic [7:0] oe_n_q; // registered enable, low = drive
    temperature_alarm_gpio_pkg::load_state_type load_q; // loader state
    logic [4:0] load_idx_q; // {alarm, word} being loaded
    logic loaded; // configuration in place
    logic load_done; // last word arrives now
    logic nv_rd_q; // registered read strobe
    logic nv_wr_q; // registered write strobe
    logic [4:0] nv_addr_q; // registered store address
    logic [31:0] nv_wdata_q; // registered store data
    logic log_busy_q; // streaming samples to card
    logic [2:0] log_idx_q; // channel being logged
    logic log_valid_q; // registered log strobe
    logic [2:0] log_ch_q; // registered log channel
    logic [31:0] log_data_q; // registered log data
    logic [31:0] prdata_q; // read data latched in setup
    logic pslverr_q; // error latched in setup
    logic apb_setup; // setup phase of a transfer
    logic apb_wr; // write access phase
    logic in_alarm; // address in alarm blocks
    logic [2:0] a_sel; // addressed alarm
    logic [1:0] a_word; // addressed word in block
    logic in_temp; // address in temperature block
    logic addr_ok; // address is mapped
    logic cfg_we; // alarm word write enable
    logic [2:0] cfg_a; // alarm being written
    logic [1:0] cfg_w; // word being written
    logic [31:0] cfg_data; // data being written

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    // two stages before anyone looks at pins or host presence
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
            host_meta_q <= 1'b0;
            host_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= gp_line_i;
            pin_sync_q <= pin_meta_q;
            host_meta_q <= host_attached_i;
            host_sync_q <= host_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timebase

    // half-second counter runs free, host requests play no part
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tick_cnt_q <= 32'h0000_0000;
        end else if (half_tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    assign half_tick = (tick_cnt_q == 32'(HALF_SEC_CYCLES - 1));

    // every second half tick makes a one-second tick
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sec_phase_q <= 1'b0;
        end else if (half_tick) begin
            sec_phase_q <= ~sec_phase_q;
        end
    end

    assign sec_tick = half_tick & sec_phase_q;

    assign sample_req_o = half_tick;

    ////////////////////////////////////////////////////////////////////////
    // latest temperature per channel

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int c = 0; c < 8; c++) begin
                temp_q[c] <= 32'h0000_0000;
            end
        end else if (sample_valid_i) begin
            temp_q[sample_ch_i] <= sample_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration loader

    assign loaded = (load_q == temperature_alarm_gpio_pkg::ST_RUN);
    assign load_done = (load_q == temperature_alarm_gpio_pkg::ST_WAIT)
        & nv_rvalid_i
        & (load_idx_q == {3'h7, temperature_alarm_gpio_pkg::AW_T2});

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            load_q <= temperature_alarm_gpio_pkg::ST_REQ;
            load_idx_q <= 5'h00;
        end else begin
            unique case (load_q)
                // issue one read
                temperature_alarm_gpio_pkg::ST_REQ: begin
                    load_q <= temperature_alarm_gpio_pkg::ST_WAIT;
                end
                // wait for the word, then step or finish
                temperature_alarm_gpio_pkg::ST_WAIT: begin
                    if (load_done) begin
                        load_q <= temperature_alarm_gpio_pkg::ST_RUN;
                    end else if (nv_rvalid_i) begin
                        load_q <= temperature_alarm_gpio_pkg::ST_REQ;
                        if (load_idx_q[1:0]
                            == temperature_alarm_gpio_pkg::AW_T2) begin
                            load_idx_q <= {load_idx_q[4:2] + 3'h1, 2'h0};
                        end else begin
                            load_idx_q <= load_idx_q + 5'h01;
                        end
                    end
                end
                // running, nothing more to load
                temperature_alarm_gpio_pkg::ST_RUN: begin
                    load_q <= temperature_alarm_gpio_pkg::ST_RUN;
                end
                default: begin
                    load_q <= temperature_alarm_gpio_pkg::ST_REQ;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    assign apb_setup = psel_i & ~penable_i;
    assign apb_wr = psel_i & penable_i & pwrite_i & ~pslverr_q;
    assign in_alarm = (paddr_i >= temperature_alarm_gpio_pkg::ALARM_BASE)
        & (paddr_i < temperature_alarm_gpio_pkg::ALARM_END)
        & (paddr_i[3:2] != 2'h3);
    // blocks start at 0x40, so alarm 0 has address bit 6 set
    assign a_sel = {~paddr_i[6], paddr_i[5:4]};
    assign a_word = paddr_i[3:2];
    assign in_temp = (paddr_i[11:5] == temperature_alarm_gpio_pkg::TEMP_BASE[11:5]);
    assign addr_ok = (paddr_i[1:0] == 2'h0) & (in_alarm | in_temp
        | (paddr_i <= temperature_alarm_gpio_pkg::STATE_OFS));

    // loader owns the alarm words until it is done
    assign cfg_we = ((load_q == temperature_alarm_gpio_pkg::ST_WAIT)
        & nv_rvalid_i) | (loaded & apb_wr & in_alarm);
    assign cfg_a = loaded ? a_sel : load_idx_q[4:2];
    assign cfg_w = loaded ? a_word : load_idx_q[1:0];
    assign cfg_data = loaded ? pwdata_i : nv_rdata_i;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int a = 0; a < 8; a++) begin
                cfg_q[a] <= 32'h0000_0000;
                t1_q[a] <= 32'h0000_0000;
                t2_q[a] <= 32'h0000_0000;
            end
        end else if (cfg_we) begin
            unique case (cfg_w)
                temperature_alarm_gpio_pkg::AW_CFG: cfg_q[cfg_a] <= cfg_data;
                temperature_alarm_gpio_pkg::AW_T1: t1_q[cfg_a] <= cfg_data;
                temperature_alarm_gpio_pkg::AW_T2: t2_q[cfg_a] <= cfg_data;
                default: begin
                end
            endcase
        end
    end

    // read strobes, software writes saved back
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            nv_rd_q <= 1'b0;
            nv_wr_q <= 1'b0;
            nv_addr_q <= 5'h00;
            nv_wdata_q <= 32'h0000_0000;
        end else begin
            nv_rd_q <= (load_q == temperature_alarm_gpio_pkg::ST_REQ);
            nv_wr_q <= loaded & apb_wr & in_alarm;
            if (load_q == temperature_alarm_gpio_pkg::ST_REQ) begin
                nv_addr_q <= load_idx_q;
            end else if (loaded & apb_wr & in_alarm) begin
                nv_addr_q <= {a_sel, a_word};
                nv_wdata_q <= pwdata_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            dir_q <= 8'h00;
            out_q <= 8'h00;
        end else if (apb_wr) begin
            if (paddr_i == temperature_alarm_gpio_pkg::DIR_OFS) begin
                dir_q <= pwdata_i[7:0];
            end
            if (paddr_i == temperature_alarm_gpio_pkg::OUT_OFS) begin
                out_q <= pwdata_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarms, one per line

    for (genvar a = 0; a < 8; a++) begin : g_alarm
        logic [31:0] temp;               // selected temperature
        logic [2:0] im;                  // input mode
        logic [1:0] om;                  // output mode
        logic gt1;                       // above first threshold
        logic lt1;                       // below first threshold
        logic gt2;                       // above second threshold
        logic lt2;                       // below second threshold
        logic alarm_d;                   // next alarm state
        logic alarm_q;                   // alarm state

        assign temp = temp_q[cfg_q[a][temperature_alarm_gpio_pkg::CFG_CH_LSB +: 3]];
        assign im = cfg_q[a][temperature_alarm_gpio_pkg::CFG_IM_LSB +: 3];
        assign om = cfg_q[a][temperature_alarm_gpio_pkg::CFG_OM_LSB +: 2];
        assign gt1 = $signed(temp) > $signed(t1_q[a]);
        assign lt1 = $signed(temp) < $signed(t1_q[a]);
        assign gt2 = $signed(temp) > $signed(t2_q[a]);
        assign lt2 = $signed(temp) < $signed(t2_q[a]);

        // comparison per input mode
        always_comb begin
            alarm_d = 1'b0;
            unique case (im)
                temperature_alarm_gpio_pkg::IM_ABOVE: alarm_d = gt1;
                temperature_alarm_gpio_pkg::IM_ABOVE_LATCH:
                    alarm_d = gt1 | (alarm_q & ~lt2);
                temperature_alarm_gpio_pkg::IM_BELOW: alarm_d = lt1;
                temperature_alarm_gpio_pkg::IM_BELOW_LATCH:
                    alarm_d = lt1 | (alarm_q & ~gt2);
                temperature_alarm_gpio_pkg::IM_WINDOW: alarm_d = lt1 | gt2;
                // unused codes never alarm
                default: alarm_d = 1'b0;
            endcase
        end

        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                alarm_q <= 1'b0;
            end else if (sec_tick & loaded) begin
                alarm_q <= alarm_d;
            end
        end

        assign alarm_state[a] = alarm_q;
        assign alarm_rise[a] = sec_tick & loaded & alarm_d & ~alarm_q;
        assign alarm_drive[a] = loaded
            & ((om == temperature_alarm_gpio_pkg::OM_ACTIVE_HIGH)
            | (om == temperature_alarm_gpio_pkg::OM_ACTIVE_LOW));
        assign alarm_level[a] =
            (om == temperature_alarm_gpio_pkg::OM_ACTIVE_LOW)
            ? ~alarm_q : alarm_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // line drivers

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pin_q <= 8'h00;
            oe_n_q <= 8'hFF;
        end else begin
            oe_n_q <= ~(alarm_drive | dir_q);
            pin_q <= (alarm_drive & alarm_level) | (~alarm_drive & out_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // logging stream

    // one sample per channel per second
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            log_busy_q <= 1'b0;
            log_idx_q <= 3'h0;
            log_valid_q <= 1'b0;
            log_ch_q <= 3'h0;
            log_data_q <= 32'h0000_0000;
        end else begin
            log_valid_q <= log_busy_q;
            if (log_busy_q) begin
                log_ch_q <= log_idx_q;
                log_data_q <= temp_q[log_idx_q];
                log_idx_q <= log_idx_q + 3'h1;
                log_busy_q <= (log_idx_q != 3'h7);
            end else if (sec_tick & ~host_sync_q) begin
                // card writes only in standalone mode
                log_busy_q <= 1'b1;
                log_idx_q <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status

    // sticky, write one clears, a new event wins
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stat_q <= 9'h000;
            mask_q <= 9'h000;
        end else begin
            if (apb_wr & (paddr_i == temperature_alarm_gpio_pkg::STAT_OFS)) begin
                stat_q <= (stat_q & ~pwdata_i[8:0]) | {load_done, alarm_rise};
            end else begin
                stat_q <= stat_q | {load_done, alarm_rise};
            end
            if (apb_wr & (paddr_i == temperature_alarm_gpio_pkg::MASK_OFS)) begin
                mask_q <= pwdata_i[8:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read path

    // read data and error latched in the setup cycle
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            pslverr_q <= ~addr_ok;
            prdata_q <= 32'h0000_0000;
            if (addr_ok & ~pwrite_i) begin
                if (in_alarm) begin
                    unique case (a_word)
                        temperature_alarm_gpio_pkg::AW_CFG:
                            prdata_q <= cfg_q[a_sel];
                        temperature_alarm_gpio_pkg::AW_T1:
                            prdata_q <= t1_q[a_sel];
                        default: prdata_q <= t2_q[a_sel];
                    endcase
                end else if (in_temp) begin
                    prdata_q <= temp_q[paddr_i[4:2]];
                end else begin
                    unique case (paddr_i)
                        temperature_alarm_gpio_pkg::DIR_OFS:
                            prdata_q <= {24'h000000, dir_q};
                        temperature_alarm_gpio_pkg::OUT_OFS:
                            prdata_q <= {24'h000000, out_q};
                        temperature_alarm_gpio_pkg::IN_OFS:
                            prdata_q <= {24'h000000, pin_sync_q};
                        temperature_alarm_gpio_pkg::STAT_OFS:
                            prdata_q <= {23'h000000, stat_q};
                        temperature_alarm_gpio_pkg::MASK_OFS:
                            prdata_q <= {23'h000000, mask_q};
                        default:
                            prdata_q <= {23'h000000, loaded, alarm_state};
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & pslverr_q;
    assign gp_line_o = pin_q;
    assign gp_line_oe_n_o = oe_n_q;
    assign nv_rd_o = nv_rd_q;
    assign nv_wr_o = nv_wr_q;
    assign nv_addr_o = nv_addr_q;
    assign nv_wdata_o = nv_wdata_q;
    assign log_valid_o = log_valid_q;
    assign log_ch_o = log_ch_q;
    assign log_data_o = log_data_q;
    assign irq_o = |(stat_q & mask_q);

endmodule : temperature_alarm_gpio

/* File: temperature_alarm_gpio_asserts.sv */
// port assertions for the alarm block
// assumes it is bound onto temperature_alarm_gpio
`timescale 1ns/100ps
module temperature_alarm_gpio_asserts (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [7:0] gp_line_oe_n_o,
    input wire logic sample_req_o,
    input wire logic host_attached_i,
    input wire logic log_valid_o,
    input wire logic [2:0] log_ch_o,
    input wire logic nv_rd_o,
    input wire logic [4:0] nv_addr_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    rst_inputs_a: assert property (disable iff (1'b0)
        sys_rst_i |=> gp_line_oe_n_o == 8'hFF) else $error("lines driven");
    nv_load_a: assert property (
        $fell(sys_rst_i) |-> ##[0:2] nv_rd_o && nv_addr_o == 5'h00)
        else $error("no config load");
    req_pulse_a: assert property (
        sample_req_o |=> !sample_req_o [*8]) else $error("sample req long");
    log_order_a: assert property (
        log_valid_o && log_ch_o != 3'h7 |=>
        log_valid_o && log_ch_o == $past(log_ch_o) + 3'h1)
        else $error("log order");
    log_end_a: assert property (
        log_valid_o && log_ch_o == 3'h7 |=> !log_valid_o)
        else $error("log burst long");
    log_host_a: assert property (
        host_attached_i [*8] ##1 host_attached_i [*8] |-> !log_valid_o)
        else $error("log while host");
    apb_ready_a: assert property (
        psel_i && penable_i |-> pready_o) else $error("no ready");
    bad_addr_a: assert property (
        psel_i && penable_i && paddr_i >= 12'h0C0 |-> pslverr_o)
        else $error("no slverr");
    cover property (nv_rd_o);
    cover property (log_valid_o && log_ch_o == 3'h7);
    cover property (irq_o);
endmodule : temperature_alarm_gpio_asserts
bind temperature_alarm_gpio temperature_alarm_gpio_asserts i_chk (.*);

/* File: alarm_env_model.sv */
// storage and converter around the alarm block
// assumes the same clock; storage latency 1 or 3 cycles
`timescale 1ns/100ps
module alarm_env_model (
    // requests from the block
    input wire logic clock_i,
    input wire logic sample_req_i,
    input wire logic nv_rd_i,
    input wire logic [4:0] nv_addr_i,
    input wire logic [255:0] temps_i,
    // answers
    output logic sample_valid_o,
    output logic [2:0] sample_ch_o,
    output logic [31:0] sample_data_o,
    output logic [31:0] nv_rdata_o,
    output logic nv_rvalid_o
);
    logic [31:0] mem [32];
    logic [31:0] t;
    logic [4:0] addr_q = 5'h00;
    logic [1:0] wait_q = 2'h0;
    logic [3:0] left_q = 4'h0;
    // alarm 0: ch0 above 100 high; alarm 1: ch1 below 50 low
    initial begin
        foreach (mem[i]) mem[i] = 32'h00000000;
        mem[0] = 32'h00000100;
        mem[1] = 32'h00000064;
        mem[4] = 32'h00000221;
        mem[5] = 32'h00000032;
    end
    always_ff @(posedge clock_i) begin
        if (nv_rd_i) addr_q <= nv_addr_i;
        if (nv_rd_i) wait_q <= nv_addr_i[0] ? 2'h3 : 2'h1;
        else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
        if (sample_req_i) left_q <= 4'h8;
        else if (left_q != 4'h0) left_q <= left_q - 4'h1;
    end
    assign nv_rvalid_o = wait_q == 2'h1;
    assign nv_rdata_o = nv_rvalid_o ? mem[addr_q] : ~mem[addr_q];
    assign sample_valid_o = left_q != 4'h0;
    assign sample_ch_o = 3'(4'h8 - left_q);
    assign t = temps_i[{sample_ch_o, 5'h00} +: 32];
    assign sample_data_o = sample_valid_o ? t : ~t;
endmodule : alarm_env_model

/* File: test_temperature_alarm_gpio.sv */
// self-checking bench for the alarm block
// assumes the env model holds the stored alarm setup
`timescale 1ns/100ps
module test_temperature_alarm_gpio;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, host_attached_i = 1'b0, pready_o, pslverr_o;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdata, log_data_o, nv_wdata_o;
    logic [31:0] sample_data_i, nv_rdata_i;
    logic [7:0] gp_line_i, gp_line_o, gp_line_oe_n_o;
    logic sample_req_o, sample_valid_i, log_valid_o, nv_rd_o, nv_wr_o;
    logic nv_rvalid_i, irq_o, err;
    logic [2:0] sample_ch_i, log_ch_o;
    logic [4:0] nv_addr_o;
    logic [255:0] temps = 256'h0;
    int n_mismatch = 0, compares = 0;
    // {temp0, temp1, expected lines 1:0}
    logic [65:0] rows [4] = '{{32'h00000096, 32'h0000003C, 2'h3},
        {32'h00000064, 32'h00000031, 2'h0}, {32'h00000065, 32'h00000032, 2'h3},
        {32'hFFFFFFFB, 32'hFFFFFFFB, 2'h0}};
    always #5 clock_i = ~clock_i;
    // pull-ups on every undriven line
    assign gp_line_i = gp_line_o | gp_line_oe_n_o;
    temperature_alarm_gpio #(.HALF_SEC_CYCLES(20)) i_temperature_alarm_gpio (.*);
    alarm_env_model i_alarm_env_model (.clock_i, .sample_req_i(sample_req_o),
        .nv_rd_i(nv_rd_o), .nv_addr_i(nv_addr_o), .temps_i(temps),
        .sample_valid_o(sample_valid_i), .sample_ch_o(sample_ch_i),
        .sample_data_o(sample_data_i), .nv_rdata_o(nv_rdata_i),
        .nv_rvalid_o(nv_rvalid_i));
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rdata = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask : apb
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (3000) @(posedge clock_i);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clock_i);
        check("reset oe", gp_line_oe_n_o, 32'h000000FF);
        sys_rst_i <= 1'b0;
        apb(1'b1, 12'h010, 32'h00000001);
        foreach (rows[i]) begin
            temps[63:0] <= {rows[i][33:2], rows[i][65:34]};
            repeat (120) @(posedge clock_i);
            check("lines", {gp_line_oe_n_o, gp_line_o},
                {8'hFC, 6'h00, rows[i][1:0]});
        end
        $display("test rows done");
        check("irq", irq_o, 32'h1);
        host_attached_i <= 1'b1;
        apb(1'b1, 12'h00C, 32'h000001FF);
        repeat (30) @(posedge clock_i);
        check("irq clr", irq_o, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        check("state", rdata, 32'h00000102);
        apb(1'b0, 12'h050, 32'h0);
        check("cfg1", rdata, 32'h00000221);
        apb(1'b1, 12'h000, 32'h00000080);
        apb(1'b1, 12'h004, 32'h00000080);
        repeat (4) @(posedge clock_i);
        check("gp oe", {gp_line_oe_n_o, gp_line_o}, 32'h00007C80);
        apb(1'b0, 12'h008, 32'h0);
        check("gp in", rdata, 32'h000000FC);
        apb(1'b0, 12'h0CC, 32'h0);
        check("unmapped", {err, rdata[30:0]}, 32'h80000000);
        $display("test registers done");
        conclude();
    end
endmodule : test_temperature_alarm_gpio
